//--- hw/tpmc_top.sv
// Timer counter core: 16-bit counter, modulus, clock select, overflow,
// up or up/down counting, coherent reads, and input capture channels.
// Assumes control bits are levels from logic on MCLK, strobes are one-cycle
// pulses, and clock and channel pins are asynchronous.
`timescale 1ns/100ps
module tpmc_top
  import tpmc_pkg::*;
(
  input  wire logic                MCLK,
  input  wire logic                RST_N,
  input  wire logic                CE,
  input  wire logic                DEBUG_HALT_MODE,
  input  wire logic [1:0]          CLOCK_SOURCE_SELECT,
  input  wire logic                CENTER_PWM_SELECT,
  input  wire logic                OVERFLOW_IRQ_ENABLE,
  input  wire tpmc_count_t         MODULUS_VALUE,
  input  wire logic                FIXED_CLK,
  input  wire logic                EXT_CLK,
  input  wire logic                COUNTER_WRITE,
  input  wire logic                COUNTER_READ_HIGH,
  input  wire logic                COUNTER_READ_LOW,
  input  wire logic                OVERFLOW_FLAG_CLEAR,
  input  wire logic [2*`TPMC_NCH-1:0] CHANNEL_MODE,
  input  wire logic [2*`TPMC_NCH-1:0] EDGE_LEVEL_SELECT,
  input  wire logic [`TPMC_NCH-1:0]   CHANNEL_IRQ_ENABLE,
  input  wire logic [`TPMC_NCH-1:0]   CHANNEL_STATUS_CONTROL_WRITE,
  input  wire logic [`TPMC_NCH-1:0]   CHANNEL_VALUE_WRITE_HIGH,
  input  wire logic [`TPMC_NCH-1:0]   CHANNEL_VALUE_WRITE_LOW,
  input  wire logic [7:0]          CHANNEL_WRITE_DATA,
  input  wire logic [`TPMC_NCH-1:0]   CHANNEL_VALUE_READ_HIGH,
  input  wire logic [`TPMC_NCH-1:0]   CHANNEL_VALUE_READ_LOW,
  input  wire logic [`TPMC_NCH-1:0]   CHANNEL_FLAG_CLEAR,
  input  wire logic [`TPMC_NCH-1:0]   CHANNEL_PIN,
  output logic [7:0]               COUNTER_HIGH_BYTE,
  output logic [7:0]               COUNTER_LOW_BYTE,
  output logic                     COUNTER_OVERFLOW_FLAG,
  output logic                     OVERFLOW_IRQ,
  output logic                     COUNTING_DOWN,
  output logic [8*`TPMC_NCH-1:0]   CHANNEL_VALUE_HIGH,
  output logic [8*`TPMC_NCH-1:0]   CHANNEL_VALUE_LOW,
  output logic [`TPMC_NCH-1:0]     CHANNEL_EVENT_FLAG,
  output logic [`TPMC_NCH-1:0]     CHANNEL_IRQ
);
  logic [1:0]  sel_q;
  logic        cpwm_q;
  logic        overflow_irq_enable_q;
  logic [2:0]  fix_s_q;
  logic [2:0]  ext_s_q;
  tpmc_count_t cnt_q;
  tpmc_count_t cnt_d;
  logic        up_q;
  logic        up_d;
  logic        tick_q;
  logic        tof_d;
  logic        tof_set;
  logic        src_edge;
  logic        step;
  tpmc_count_t term;
  logic        at_term;
  logic        at_zero;
  logic        up_wrap;
  logic        turn_down;
  logic        turn_up;
  tpmc_count_t cnt_inc;
  tpmc_count_t cnt_dec;

  // Counter clock source; select zero gives no edge at all
  assign src_edge = (sel_q == `TPMC_SEL_BUS) ||
                    (sel_q == `TPMC_SEL_FIXED && fix_s_q[1] && !fix_s_q[2]) ||
                    (sel_q == `TPMC_SEL_EXT && ext_s_q[1] && !ext_s_q[2]);
  // Counter freezes in debug halt and while stopped, keeping its value unless COUNTER_WRITE clears it
  assign step      = src_edge && !DEBUG_HALT_MODE && !COUNTER_WRITE;
  assign term      = (MODULUS_VALUE == `TPMC_CNT_ZERO) ? `TPMC_CNT_MAX : MODULUS_VALUE;
  assign at_term   = (cnt_q == term);
  assign at_zero   = (cnt_q == `TPMC_CNT_ZERO);
  assign cnt_inc   = cnt_q + `TPMC_CNT_ONE;
  assign cnt_dec   = cnt_q - `TPMC_CNT_ONE;
  assign up_wrap   = !cpwm_q && at_term;
  assign turn_down = cpwm_q && up_q && at_term;
  assign turn_up   = cpwm_q && !up_q && at_zero;
  assign cnt_d     = COUNTER_WRITE ? `TPMC_CNT_ZERO :
                     !step ? cnt_q :
                     up_wrap ? `TPMC_CNT_ZERO :
                     turn_down ? cnt_dec :
                     turn_up ? cnt_inc :
                     (cpwm_q && !up_q) ? cnt_dec : cnt_inc;
  assign up_d      = (COUNTER_WRITE || !cpwm_q) ? 1'b1 :
                     (step && turn_down) ? 1'b0 :
                     (step && turn_up) ? 1'b1 : up_q;
  assign tof_set   = step && (up_wrap || turn_down);
  assign tof_d     = tof_set || (COUNTER_OVERFLOW_FLAG && !OVERFLOW_FLAG_CLEAR);

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      sel_q   <= `TPMC_SEL_OFF;
      cpwm_q  <= 1'b0;
      overflow_irq_enable_q  <= 1'b0;
      fix_s_q <= 3'h0;
      ext_s_q <= 3'h0;
    end else if (CE) begin
      sel_q   <= CLOCK_SOURCE_SELECT;
      cpwm_q  <= CENTER_PWM_SELECT;
      overflow_irq_enable_q  <= OVERFLOW_IRQ_ENABLE;
      fix_s_q <= {fix_s_q[1:0], FIXED_CLK};
      ext_s_q <= {ext_s_q[1:0], EXT_CLK};
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q                 <= `TPMC_CNT_ZERO;
      up_q                  <= 1'b1;
      tick_q                <= 1'b0;
      COUNTER_OVERFLOW_FLAG <= 1'b0;
      OVERFLOW_IRQ          <= 1'b0;
      COUNTING_DOWN         <= 1'b0;
    end else if (CE) begin
      cnt_q                 <= cnt_d;
      up_q                  <= up_d;
      tick_q                <= step;
      COUNTER_OVERFLOW_FLAG <= tof_d;
      OVERFLOW_IRQ          <= tof_d && OVERFLOW_IRQ_ENABLE;
      COUNTING_DOWN         <= !up_d;
    end
  end

  tpmc_read_latch u_cnt_rd (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .ce      (CE),
    .freeze  (DEBUG_HALT_MODE),
    .value   (cnt_q),
    .rd_hi   (COUNTER_READ_HIGH),
    .rd_lo   (COUNTER_READ_LOW),
    .restart (COUNTER_WRITE),
    .hi_byte (COUNTER_HIGH_BYTE),
    .lo_byte (COUNTER_LOW_BYTE)
  );

  for (genvar i = 0; i < `TPMC_NCH; i++) begin : g_ch
    tpmc_channel u_ch (
      .clk          (MCLK),
      .rst_n        (RST_N),
      .ce           (CE),
      .debug        (DEBUG_HALT_MODE),
      .cpwm         (cpwm_q),
      .pin_is_clock (i == `TPMC_EXT_CHANNEL && sel_q == `TPMC_SEL_EXT),
      .mode         (CHANNEL_MODE[2*i +: 2]),
      .els          (EDGE_LEVEL_SELECT[2*i +: 2]),
      .irq_en       (CHANNEL_IRQ_ENABLE[i]),
      .sc_write     (CHANNEL_STATUS_CONTROL_WRITE[i]),
      .wr_hi        (CHANNEL_VALUE_WRITE_HIGH[i]),
      .wr_lo        (CHANNEL_VALUE_WRITE_LOW[i]),
      .wr_data      (CHANNEL_WRITE_DATA),
      .rd_hi        (CHANNEL_VALUE_READ_HIGH[i]),
      .rd_lo        (CHANNEL_VALUE_READ_LOW[i]),
      .flag_clear   (CHANNEL_FLAG_CLEAR[i]),
      .pin          (CHANNEL_PIN[i]),
      .count        (cnt_q),
      .count_tick   (tick_q),
      .value_hi     (CHANNEL_VALUE_HIGH[8*i +: 8]),
      .value_lo     (CHANNEL_VALUE_LOW[8*i +: 8]),
      .flag         (CHANNEL_EVENT_FLAG[i]),
      .irq          (CHANNEL_IRQ[i])
    );
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence top_reached;
    CE && step && cpwm_q && up_q && at_term && term != `TPMC_CNT_ZERO;
  endsequence
  sequence left_downward;
    cnt_q == $past(term) - `TPMC_CNT_ONE && COUNTER_OVERFLOW_FLAG;
  endsequence

  a_stop_holds_count: assert property (CE && sel_q == `TPMC_SEL_OFF && !COUNTER_WRITE
    |=> $stable(cnt_q))
    else $error("stopped counter changed");
  a_wrap_sets_overflow: assert property (CE && step && !cpwm_q && at_term
    |=> cnt_q == `TPMC_CNT_ZERO && COUNTER_OVERFLOW_FLAG)
    else $error("wrap did not clear count and set overflow");
  a_updown_top_turn: assert property (top_reached |=> left_downward and !up_q)
    else $error("up/down turn at terminal count wrong");
  a_updown_zero_turn: assert property (CE && step && cpwm_q && !up_q && at_zero
    |=> cnt_q == `TPMC_CNT_ONE && up_q)
    else $error("up/down turn at zero wrong");
  a_overflow_irq_gate: assert property (CE && tof_d && OVERFLOW_IRQ_ENABLE
    |=> OVERFLOW_IRQ ##0 COUNTER_OVERFLOW_FLAG)
    else $error("overflow interrupt missing");
  a_counter_write_clears: assert property (CE && COUNTER_WRITE |=> cnt_q == `TPMC_CNT_ZERO)
    else $error("counter write did not clear counter");
  a_debug_freezes_count: assert property (CE && DEBUG_HALT_MODE && !COUNTER_WRITE
    |=> $stable(cnt_q))
    else $error("counter moved during debug halt");
  a_ext_needs_edge: assert property (CE && sel_q == `TPMC_SEL_EXT && !ext_s_q[1]
    && !COUNTER_WRITE |=> $stable(cnt_q))
    else $error("external clock counted without synchronized edge");
endmodule

//--- hw/tpmc_params.svh
// Constants of the timer counter with input capture.
// Assumes inclusion by bare name from the package and modules.
`ifndef TPMC_PARAMS_SVH
`define TPMC_PARAMS_SVH
`define TPMC_CNT_W        16
`define TPMC_NCH          2
`define TPMC_CNT_ZERO     16'h0000
`define TPMC_CNT_MAX      16'hffff
`define TPMC_CNT_ONE      16'h0001
`define TPMC_SEL_OFF      2'h0
`define TPMC_SEL_BUS      2'h1
`define TPMC_SEL_FIXED    2'h2
`define TPMC_SEL_EXT      2'h3
`define TPMC_MODE_CAPTURE 2'h0
`define TPMC_MODE_COMPARE 2'h1
`define TPMC_ELS_NONE     2'h0
`define TPMC_ELS_RISE     2'h1
`define TPMC_ELS_FALL     2'h2
`define TPMC_ELS_BOTH     2'h3
`define TPMC_EXT_CHANNEL  0
`endif

//--- hw/tpmc_pkg.sv
// Types and mode decoding of the timer counter with input capture.
// Assumes the constants header is on the include path.
`include "tpmc_params.svh"
package tpmc_pkg;
  typedef logic [`TPMC_CNT_W-1:0] tpmc_count_t;
  typedef enum logic [1:0] {FUNC_CAPTURE, FUNC_COMPARE, FUNC_EPWM, FUNC_CPWM} tpmc_func_e;

  // Channel function from center select and the two mode bits
  function automatic tpmc_func_e tpmc_func(input logic cpwm, input logic [1:0] mode);
    tpmc_func_e f;
    f = FUNC_CAPTURE;
    if (cpwm)
      f = FUNC_CPWM;
    else if (mode[1])
      f = FUNC_EPWM;
    else if (mode == `TPMC_MODE_COMPARE)
      f = FUNC_COMPARE;
    return f;
  endfunction
endpackage

//--- hw/tpmc_read_latch.sv
// Coherent 16-bit byte-wise read buffer.
// Assumes read strobes are one-cycle pulses on the same clock.
`timescale 1ns/100ps
module tpmc_read_latch
  import tpmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        freeze,
  input  wire tpmc_count_t value,
  input  wire logic        rd_hi,
  input  wire logic        rd_lo,
  input  wire logic        restart,
  output logic [7:0]       hi_byte,
  output logic [7:0]       lo_byte
);
  logic        latched_q;
  logic        first_hi_q;
  tpmc_count_t buf_q;
  logic        latched_d;
  logic        first_hi_d;
  tpmc_count_t buf_d;
  logic        one_rd;
  logic        take;
  logic        done;
  tpmc_count_t shown;

  assign shown      = {hi_byte, lo_byte};
  assign one_rd     = rd_hi ^ rd_lo;
  assign take       = !freeze && !latched_q && one_rd;
  assign done       = !freeze && latched_q && (first_hi_q ? rd_lo : rd_hi);
  assign latched_d  = restart ? 1'b0 : take ? 1'b1 : done ? 1'b0 : latched_q;
  assign first_hi_d = take ? rd_hi : first_hi_q;
  // The first read returns the shown word, so the buffer keeps exactly that word
  assign buf_d      = take ? shown : buf_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_q  <= 1'b0;
      first_hi_q <= 1'b0;
      buf_q      <= `TPMC_CNT_ZERO;
      hi_byte    <= 8'h00;
      lo_byte    <= 8'h00;
    end else if (ce) begin
      latched_q  <= latched_d;
      first_hi_q <= first_hi_d;
      buf_q      <= buf_d;
      // While halted the live value is shown, not the buffer
      {hi_byte, lo_byte} <= (latched_d && !freeze) ? buf_d : value;
    end
  end
endmodule

//--- hw/tpmc_channel.sv
// One timer channel: capture, software compare flag, value register.
// Assumes the pin is asynchronous and counter inputs share the clock.
`timescale 1ns/100ps
module tpmc_channel
  import tpmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        debug,
  input  wire logic        cpwm,
  input  wire logic        pin_is_clock,
  input  wire logic [1:0]  mode,
  input  wire logic [1:0]  els,
  input  wire logic        irq_en,
  input  wire logic        sc_write,
  input  wire logic        wr_hi,
  input  wire logic        wr_lo,
  input  wire logic [7:0]  wr_data,
  input  wire logic        rd_hi,
  input  wire logic        rd_lo,
  input  wire logic        flag_clear,
  input  wire logic        pin,
  input  wire tpmc_count_t count,
  input  wire logic        count_tick,
  output logic [7:0]       value_hi,
  output logic [7:0]       value_lo,
  output logic             flag,
  output logic             irq
);
  logic [2:0]  pin_s_q;
  tpmc_count_t val_q;
  tpmc_count_t val_d;
  tpmc_func_e  func;
  logic        is_cap;
  logic        rise;
  logic        fall;
  logic        edge_hit;
  logic        capture;
  logic        match;
  logic        flag_d;

  assign func     = tpmc_func(cpwm, mode);
  assign is_cap   = (func == FUNC_CAPTURE) && !pin_is_clock;
  assign rise     = pin_s_q[1] && !pin_s_q[2];
  assign fall     = !pin_s_q[1] && pin_s_q[2];
  assign edge_hit = (els == `TPMC_ELS_RISE && rise) ||
                    (els == `TPMC_ELS_FALL && fall) ||
                    (els == `TPMC_ELS_BOTH && (rise || fall));
  assign capture  = is_cap && edge_hit;
  assign match    = (func == FUNC_COMPARE) && count_tick && (count == val_q);
  // Writes are ignored while capturing
  assign val_d    = capture ? count :
                    (func == FUNC_CAPTURE) ? val_q :
                    {wr_hi ? wr_data : val_q[15:8], wr_lo ? wr_data : val_q[7:0]};
  assign flag_d   = capture || match || (flag && !flag_clear);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s_q <= 3'h0;
      val_q   <= `TPMC_CNT_ZERO;
      flag    <= 1'b0;
      irq     <= 1'b0;
    end else if (ce) begin
      pin_s_q <= {pin_s_q[1:0], pin};
      val_q   <= val_d;
      flag    <= flag_d;
      irq     <= flag_d && irq_en;
    end
  end

  tpmc_read_latch u_rd (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .freeze  (debug),
    .value   (val_q),
    .rd_hi   (rd_hi && func == FUNC_CAPTURE),
    .rd_lo   (rd_lo && func == FUNC_CAPTURE),
    .restart (sc_write),
    .hi_byte (value_hi),
    .lo_byte (value_lo)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence cap_seen;
    ce && capture;
  endsequence

  a_capture_takes_count: assert property (cap_seen |=> val_q == $past(count))
    else $error("capture did not store the counter");
  a_capture_sets_flag: assert property (cap_seen |=> flag)
    else $error("capture did not set the event flag");
  a_capture_write_ignored: assert property (
    ce && func == FUNC_CAPTURE && !capture && (wr_hi || wr_lo) |=> $stable(val_q))
    else $error("write changed a capture value");
  a_irq_gated_enable: assert property (ce && flag_d && !irq_en |=> !irq)
    else $error("channel interrupt without enable");
  a_clock_pin_no_capture: assert property (ce && pin_is_clock && !match && !wr_hi && !wr_lo
    |=> $stable(val_q))
    else $error("clock pin channel captured");
endmodule

//--- verif/tpmc_pins_model.sv
// Far-side pin model: external clock, fixed frequency clock and event pins.
// Assumes the bench starts clock bursts; both clocks stand low between bursts.
`timescale 1ns/100ps
module tpmc_pins_model (
  input  wire logic       clk,
  input  wire logic [1:0] pin_lvl,
  output logic            ext_clk,
  output logic            fixed_clk,
  output logic [1:0]      pins
);
  // Event pins are always driven, so no released level is needed
  assign pins = pin_lvl;

  initial begin
    ext_clk = 1'b0;
    fixed_clk = 1'b0;
  end

  // Sends n rising edges, each level lasting hp bus clocks, but at least 2 for the external clock and at least 1 for the fixed clock
  task automatic burst(input logic ext, input int n, input int hp);
    int p;
    p = hp;
    if (ext && p < 2)
      p = 2;
    if (p < 1)
      p = 1;
    repeat (n) begin
      repeat (p) @(negedge clk);
      if (ext)
        ext_clk = 1'b1;
      else
        fixed_clk = 1'b1;
      repeat (p) @(negedge clk);
      ext_clk = 1'b0;
      fixed_clk = 1'b0;
    end
  endtask
endmodule

//--- verif/tpmc_top_tb.sv
// Self-checking bench of the timer core: counting, overflow, reads, capture.
// Assumes the design package and the pin model are compiled first.
`timescale 1ns/100ps
module tpmc_top_tb
  import tpmc_pkg::*;
;
  localparam int CW = 0, RDH = 1, RDL = 2, OVC = 3, SCW = 4, WRH = 6, WRL = 8, VRH = 10, FCL = 14;
  logic        mclk, rst_n, dbg, cpwm, oie, ext_clk, fix_clk, ovf, ovf_irq, down;
  logic [1:0]  sel, cien, pin_lvl, pins, cflag, cirq;
  logic [3:0]  mode, els;
  logic [7:0]  wdat, cnt_hi, cnt_lo;
  logic [15:0] st, cv_hi, cv_lo;
  tpmc_count_t modv, ec, cap;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  wire tpmc_count_t cnt = {cnt_hi, cnt_lo};
  wire tpmc_count_t v0 = {cv_hi[7:0], cv_lo[7:0]};
  wire tpmc_count_t v1 = {cv_hi[15:8], cv_lo[15:8]};

  tpmc_top tpmc_top_inst (
    .MCLK(mclk), .RST_N(rst_n), .CE(1'b1), .DEBUG_HALT_MODE(dbg), .CLOCK_SOURCE_SELECT(sel),
    .CENTER_PWM_SELECT(cpwm), .OVERFLOW_IRQ_ENABLE(oie), .MODULUS_VALUE(modv), .FIXED_CLK(fix_clk),
    .EXT_CLK(ext_clk), .COUNTER_WRITE(st[CW]), .COUNTER_READ_HIGH(st[RDH]), .COUNTER_READ_LOW(st[RDL]),
    .OVERFLOW_FLAG_CLEAR(st[OVC]), .CHANNEL_MODE(mode), .EDGE_LEVEL_SELECT(els), .CHANNEL_IRQ_ENABLE(cien),
    .CHANNEL_STATUS_CONTROL_WRITE(st[5:4]), .CHANNEL_VALUE_WRITE_HIGH(st[7:6]),
    .CHANNEL_VALUE_WRITE_LOW(st[9:8]), .CHANNEL_WRITE_DATA(wdat), .CHANNEL_VALUE_READ_HIGH(st[11:10]),
    .CHANNEL_VALUE_READ_LOW(st[13:12]), .CHANNEL_FLAG_CLEAR(st[15:14]), .CHANNEL_PIN(pins),
    .COUNTER_HIGH_BYTE(cnt_hi), .COUNTER_LOW_BYTE(cnt_lo), .COUNTER_OVERFLOW_FLAG(ovf),
    .OVERFLOW_IRQ(ovf_irq), .COUNTING_DOWN(down), .CHANNEL_VALUE_HIGH(cv_hi), .CHANNEL_VALUE_LOW(cv_lo),
    .CHANNEL_EVENT_FLAG(cflag), .CHANNEL_IRQ(cirq)
  );

  tpmc_pins_model tpmc_pins_model_inst (
    .clk(mclk), .pin_lvl(pin_lvl), .ext_clk(ext_clk), .fixed_clk(fix_clk), .pins(pins)
  );

  always #10 mclk = ~mclk;

  task automatic summarize;
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 70000) begin
      miscompares = miscompares + 1;
      summarize();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic pulse(input int b);
    st = 16'h0001 << b;
    tick(1);
    st = 16'h0000;
  endtask

  // Bus clock selected for exactly n edges, then stopped and settled
  task automatic run(input int n);
    sel = 2'h1;
    tick(n);
    sel = 2'h0;
    tick(4);
    ec = ec + n[15:0];
  endtask

  task automatic clr;
    pulse(CW);
    tick(2);
    ec = 16'h0000;
  endtask

  task automatic edge1;
    pin_lvl[1] = ~pin_lvl[1];
    tick(6);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  initial begin
    {mclk, rst_n, dbg, cpwm, oie, sel, cien, pin_lvl, mode, els, wdat, st} = '0;
    {modv, ec, cap} = '0;
    tick(16);
    rst_n = 1'b1;
    chk(cnt, 16'h0000);
    chk({9'h0, ovf, ovf_irq, down, cflag, cirq}, 16'h0000);
    tick(5);
    chk(cnt, 16'h0000);
    run(10);
    chk(cnt, 16'h000a);
    tick(20);
    chk(cnt, 16'h000a);
    sel = 2'h2;
    tpmc_pins_model_inst.burst(1'b0, 6, 2);
    tick(6);
    sel = 2'h0;
    tick(4);
    chk(cnt, 16'h0010);
    els[1:0] = 2'h3;
    sel = 2'h3;
    pin_lvl[0] = 1'b1;
    tpmc_pins_model_inst.burst(1'b1, 5, 4);
    pin_lvl[0] = 1'b0;
    tick(6);
    sel = 2'h0;
    tick(4);
    chk(cnt, 16'h0015);
    chk({15'h0, cflag[0]}, 16'h0000);
    modv = 16'h0005;
    oie = 1'b1;
    clr();
    chk(cnt, 16'h0000);
    run(5);
    chk({cnt[7:0], 6'h0, ovf, ovf_irq}, 16'h0500);
    run(1);
    chk({cnt[7:0], 6'h0, ovf, ovf_irq}, 16'h0003);
    oie = 1'b0;
    tick(3);
    chk({14'h0, ovf, ovf_irq}, 16'h0002);
    pulse(OVC);
    tick(2);
    cpwm = 1'b1;
    modv = 16'h0003;
    clr();
    run(3);
    chk({cnt[7:0], 6'h0, ovf, down}, 16'h0300);
    run(1);
    chk({cnt[7:0], 6'h0, ovf, down}, 16'h0203);
    pulse(OVC);
    tick(2);
    run(3);
    chk({cnt[7:0], 6'h0, ovf, down}, 16'h0100);
    cpwm = 1'b0;
    modv = 16'h0000;
    clr();
    run(65535);
    chk({cnt[14:0], ovf}, 16'hfffe);
    run(1);
    chk({cnt[14:0], ovf}, 16'h0001);
    pulse(OVC);
    tick(2);
    run(291);
    pulse(RDH);
    tick(1);
    run(256);
    chk(cnt, 16'h0123);
    pulse(RDL);
    tick(2);
    chk(cnt, ec);
    pulse(RDL);
    tick(1);
    run(3);
    clr();
    chk(cnt, 16'h0000);
    for (int e = 0; e < 4; e++) begin
      els[3:2] = e[1:0];
      cien[1] = e[1];
      for (int f = 0; f < 2; f++) begin
        run(7);
        edge1();
        if (e[f])
          cap = ec;
        chk(v1, cap);
        chk({14'h0, cflag[1], cirq[1]}, {14'h0, e[f], e[f] & e[1]});
        pulse(FCL + 1);
        tick(2);
      end
    end
    wdat = 8'haa;
    pulse(WRH + 1);
    tick(2);
    chk(v1, cap);
    pulse(VRH + 1);
    tick(1);
    run(7);
    edge1();
    chk(v1, cap);
    cap = ec;
    pulse(SCW + 1);
    tick(2);
    chk(v1, cap);
    pulse(FCL + 1);
    tick(2);
    dbg = 1'b1;
    sel = 2'h1;
    tick(8);
    edge1();
    chk({v1[14:0], cflag[1]}, {ec[14:0], 1'b1});
    sel = 2'h0;
    tick(4);
    dbg = 1'b0;
    tick(2);
    chk(cnt, ec);
    mode[1:0] = 2'h1;
    els[1:0] = 2'h0;
    cap = ec + 16'h0003;
    wdat = cap[15:8];
    pulse(WRH);
    wdat = cap[7:0];
    pulse(WRL);
    tick(2);
    chk(v0, cap);
    run(5);
    chk({15'h0, cflag[0]}, 16'h0001);
    summarize();
  end
endmodule
